// [include/tsc_pkg.sv]
`default_nettype none
// Shared constants and carriers of the thermostat serial control core
package tsc_pkg;

  // Serial command codes, sent least significant bit first
  localparam logic [7:0] TSC_CMD_RD_TEMP = 8'hAA;
  localparam logic [7:0] TSC_CMD_RD_CNT = 8'hA0;
  localparam logic [7:0] TSC_CMD_RD_SLOPE = 8'hA9;
  localparam logic [7:0] TSC_CMD_START = 8'hEE;
  localparam logic [7:0] TSC_CMD_STOP = 8'h22;
  localparam logic [7:0] TSC_CMD_WR_UPPER = 8'h01;
  localparam logic [7:0] TSC_CMD_WR_LOWER = 8'h02;
  localparam logic [7:0] TSC_CMD_RD_UPPER = 8'hA1;
  localparam logic [7:0] TSC_CMD_RD_LOWER = 8'hA2;
  localparam logic [7:0] TSC_CMD_WR_CFG = 8'h0C;
  localparam logic [7:0] TSC_CMD_RD_CFG = 8'hAC;

  // Frame layout, in link clock cycles
  localparam logic [4:0] TSC_CMD_BITS = 5'h08;
  localparam logic [4:0] TSC_WORD_BITS = 5'h09;
  localparam logic [4:0] TSC_CFG_BITS = 5'h08;

  // Field positions of config_status
  localparam int TSC_CFG_DONE = 7;
  localparam int TSC_CFG_UPPER_FLAG = 6;
  localparam int TSC_CFG_LOWER_FLAG = 5;
  localparam int TSC_CFG_NV_BUSY = 4;
  localparam int TSC_CFG_ONE = 3;
  localparam int TSC_CFG_ZERO = 2;
  localparam int TSC_CFG_HOST_MODE = 1;
  localparam int TSC_CFG_SINGLE = 0;

  // Power-up and shipped values
  localparam logic [8:0] TSC_TEMP_RST = 9'h188;
  localparam logic [8:0] TSC_UPPER_RST = 9'h01E;
  localparam logic [8:0] TSC_LOWER_RST = 9'h014;
  localparam logic [8:0] TSC_WORD_RST = 9'h000;
  localparam logic TSC_HOST_MODE_RST = 1'b0;
  localparam logic TSC_SINGLE_RST = 1'b0;

  // Nonvolatile write time; longest time, rounded down to cycles
  localparam int TSC_REF_CLK_HZ = 100_000_000;
  localparam int TSC_NV_WRITE_MS = 10;
  localparam int TSC_NV_WRITE_CYCLES = TSC_NV_WRITE_MS * (TSC_REF_CLK_HZ / 1000);

  // Command event passed from the link domain
  typedef struct packed {
    logic [7:0] cmd;
    logic [8:0] data;
  } tsc_evt_t;

  // Register image frozen for the link while a frame is open
  typedef struct packed {
    logic [8:0] temp;
    logic [8:0] upper;
    logic [8:0] lower;
    logic [8:0] count;
    logic [8:0] slope;
    logic [7:0] cfg;
  } tsc_snap_t;

endpackage
`default_nettype wire

// [hw/tsc_core.sv]
`timescale 1ns/10ps
`default_nettype none
module tsc_core
  import tsc_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = TSC_NV_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic frame_sel,
  input wire logic clock_convert_pin,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  input wire logic [8:0] sense_temp,
  input wire logic [8:0] sense_count,
  input wire logic [8:0] sense_slope,
  input wire logic sense_valid,
  output logic conv_start,
  output logic over_limit_out,
  output logic under_limit_out,
  output logic hysteresis_out
);

  localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);

  // Conversion sequencer states
  typedef enum logic [0:0] {
    TSC_IDLE,
    TSC_CONV
  } tsc_state_t;

  // ---------------- Link domain (serial clock) ----------------

  logic link_rst_n; // Frame low clears the frame state
  logic [4:0] bit_cnt_q; // Edges seen in this frame, saturating
  logic [7:0] cmd_q; // Command byte being shifted in
  logic [8:0] wsh_q; // Write data shifter
  tsc_evt_t evt_q; // Payload of the last finished command
  logic evt_tog_q; // Flips once per finished command
  logic send_q; // Data line owned until the next rising edge
  logic dq_bit_q; // Bit on the data line
  logic [7:0] next_cmd; // Command byte including this edge's bit
  logic [8:0] rd_word; // Word selected for a read command
  logic [4:0] rd_len; // Length of that word
  logic rd_cmd; // Command is a read
  logic [4:0] rd_idx; // Bit index of the next output bit
  tsc_snap_t snap_q; // Frozen register image, ref domain

  // Frame select low aborts the link side, all but the command handover
  assign link_rst_n = arst_n & frame_sel;

  // Command byte assembles lsb first
  assign next_cmd = {dq_in, cmd_q[7:1]};

  // Rising edge: sample command and write data
  always_ff @(posedge clock_convert_pin or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 5'h00;
      cmd_q <= 8'h00;
      wsh_q <= TSC_WORD_RST;
    end else begin
      // Saturate so a long frame never wraps into a new command
      if (bit_cnt_q != 5'h1F) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (bit_cnt_q < TSC_CMD_BITS) begin
        cmd_q <= next_cmd;
      end else begin
        wsh_q <= {dq_in, wsh_q[8:1]};
      end
    end
  end

  // Rising edge: hand commands over; frame low must not wipe them before the ref side looks
  always_ff @(posedge clock_convert_pin or negedge arst_n) begin
    if (!arst_n) begin
      evt_q <= '0;
      evt_tog_q <= 1'b0;
    end else if (bit_cnt_q == TSC_CMD_BITS - 5'h01) begin
      // Start, stop and the slope read fire on the last command bit
      if (next_cmd == TSC_CMD_START || next_cmd == TSC_CMD_STOP ||
          next_cmd == TSC_CMD_RD_SLOPE) begin
        evt_q <= '{cmd: next_cmd, data: TSC_WORD_RST};
        evt_tog_q <= ~evt_tog_q;
      end
    end else if (bit_cnt_q == TSC_CMD_BITS + TSC_WORD_BITS - 5'h01) begin
      // Ninth data bit completes a trip point write
      if (cmd_q == TSC_CMD_WR_UPPER || cmd_q == TSC_CMD_WR_LOWER) begin
        evt_q <= '{cmd: cmd_q, data: {dq_in, wsh_q[8:1]}};
        evt_tog_q <= ~evt_tog_q;
      end
    end else if (bit_cnt_q == TSC_CMD_BITS + TSC_CFG_BITS - 5'h01) begin
      // Eighth data bit completes a config write
      if (cmd_q == TSC_CMD_WR_CFG) begin
        evt_q <= '{cmd: cmd_q, data: {1'b0, dq_in, wsh_q[8:2]}};
        evt_tog_q <= ~evt_tog_q;
      end
    end
  end

  // Read source select from the frozen image
  always_comb begin
    rd_word = TSC_WORD_RST;
    rd_len = TSC_WORD_BITS;
    rd_cmd = 1'b1;
    case (cmd_q)
      TSC_CMD_RD_TEMP: rd_word = snap_q.temp;
      TSC_CMD_RD_UPPER: rd_word = snap_q.upper;
      TSC_CMD_RD_LOWER: rd_word = snap_q.lower;
      TSC_CMD_RD_CNT: rd_word = snap_q.count;
      TSC_CMD_RD_SLOPE: rd_word = snap_q.slope;
      TSC_CMD_RD_CFG: begin
        rd_word = {1'b0, snap_q.cfg};
        rd_len = TSC_CFG_BITS;
      end
      default: rd_cmd = 1'b0;
    endcase
  end

  assign rd_idx = bit_cnt_q - TSC_CMD_BITS;

  // Falling edge: launch the next read bit, zeros past the msb
  always_ff @(negedge clock_convert_pin or negedge link_rst_n) begin
    if (!link_rst_n) begin
      send_q <= 1'b0;
      dq_bit_q <= 1'b0;
    end else if (rd_cmd && bit_cnt_q >= TSC_CMD_BITS) begin
      send_q <= 1'b1;
      dq_bit_q <= (rd_idx < rd_len) ? rd_word[rd_idx[3:0]] : 1'b0;
    end else begin
      send_q <= 1'b0;
      dq_bit_q <= 1'b0;
    end
  end

  // Drive only while the clock is low; released as soon as it rises
  assign dq_out = dq_bit_q;
  assign dq_oe_n = ~(send_q & ~clock_convert_pin);

  // ---------------- Reference domain ----------------

  logic frm_s1_q, frm_s2_q; // Frame select synchroniser
  logic pin_s1_q, pin_s2_q, pin_s3_q; // Convert pin synchroniser plus edge stage
  logic tog_s1_q, tog_s2_q, tog_s3_q; // Command toggle synchroniser plus edge stage
  logic evt_pulse; // One cycle per finished command
  tsc_state_t state_q; // Conversion sequencer
  logic start_pend_q; // A start waits for the sequencer
  logic cont_q; // Continuous conversion by command
  logic standalone_en; // Pin acts as a convert input
  logic conv_want; // Keep converting after this one
  logic conv_start_q; // Start pulse to the sensor
  logic [8:0] temp_q, upper_q, lower_q, count_q, slope_q; // Data registers
  logic upper_flag_q, lower_flag_q; // Sticky flags
  logic host_mode_q, single_q; // Nonvolatile mode bits
  logic [NVW-1:0] nv_cnt_q; // Nonvolatile write timer
  logic over_q, under_q, hyst_q; // Thermostat outputs
  logic at_upper, at_lower; // Compare of the fresh sample
  logic nv_write; // A command that writes nonvolatile cells
  logic [7:0] cfg_img; // config_status as read

  // Pins and toggle pass two flops before any logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frm_s1_q <= 1'b0;
      frm_s2_q <= 1'b0;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      frm_s1_q <= frame_sel;
      frm_s2_q <= frm_s1_q;
      pin_s1_q <= clock_convert_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      tog_s1_q <= evt_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Payload is stable for many link cycles after the toggle
  assign evt_pulse = tog_s2_q ^ tog_s3_q;

  // Stand-alone convert only with host mode 0 and frame low
  assign standalone_en = ~host_mode_q & ~frm_s2_q;
  assign conv_want = cont_q | (standalone_en & ~pin_s2_q);

  // Start requests from command or pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_pend_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      if (evt_pulse && evt_q.cmd == TSC_CMD_START) begin
        start_pend_q <= 1'b1;
        cont_q <= ~single_q;
      end else if (standalone_en && pin_s3_q && !pin_s2_q) begin
        start_pend_q <= 1'b1;
      end else if (state_q == TSC_IDLE) begin
        start_pend_q <= 1'b0;
      end
      // Stop lets the running conversion finish
      if (evt_pulse && evt_q.cmd == TSC_CMD_STOP) begin
        cont_q <= 1'b0;
      end
    end
  end

  // Fresh sample against the trip points, two's complement
  assign at_upper = $signed(sense_temp) >= $signed(upper_q);
  assign at_lower = $signed(sense_temp) <= $signed(lower_q);

  // Conversion sequencer; done bit is the idle state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= TSC_IDLE;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        TSC_IDLE: begin
          if (start_pend_q) begin
            state_q <= TSC_CONV;
            conv_start_q <= 1'b1;
          end
        end
        TSC_CONV: begin
          if (sense_valid) begin
            // One conversion unless more are wanted
            if (conv_want) begin
              conv_start_q <= 1'b1;
            end else begin
              state_q <= TSC_IDLE;
            end
          end
        end
        default: state_q <= TSC_IDLE;
      endcase
    end
  end

  // Results and thermostat outputs change only at completion
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_q <= TSC_TEMP_RST;
      slope_q <= TSC_WORD_RST;
      over_q <= 1'b0;
      under_q <= 1'b0;
      hyst_q <= 1'b0;
    end else if (state_q == TSC_CONV && sense_valid) begin
      temp_q <= sense_temp;
      slope_q <= sense_slope;
      over_q <= at_upper;
      under_q <= at_lower;
      if (at_upper) begin
        hyst_q <= 1'b1;
      end else if (at_lower) begin
        hyst_q <= 1'b0;
      end
    end
  end

  // Count remaining; slope read loads the accumulator into it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= TSC_WORD_RST;
    end else if (state_q == TSC_CONV && sense_valid) begin
      count_q <= sense_count;
    end else if (evt_pulse && evt_q.cmd == TSC_CMD_RD_SLOPE) begin
      count_q <= slope_q;
    end
  end

  // Trip points; reset stands for the stored nonvolatile value
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_q <= TSC_UPPER_RST;
      lower_q <= TSC_LOWER_RST;
    end else if (evt_pulse) begin
      if (evt_q.cmd == TSC_CMD_WR_UPPER) begin
        upper_q <= evt_q.data;
      end
      if (evt_q.cmd == TSC_CMD_WR_LOWER) begin
        lower_q <= evt_q.data;
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_flag_q <= 1'b0;
      lower_flag_q <= 1'b0;
    end else begin
      if (state_q == TSC_CONV && sense_valid && at_upper) begin
        upper_flag_q <= 1'b1;
      end else if (evt_pulse && evt_q.cmd == TSC_CMD_WR_CFG &&
                   !evt_q.data[TSC_CFG_UPPER_FLAG]) begin
        upper_flag_q <= 1'b0;
      end
      if (state_q == TSC_CONV && sense_valid && at_lower) begin
        lower_flag_q <= 1'b1;
      end else if (evt_pulse && evt_q.cmd == TSC_CMD_WR_CFG &&
                   !evt_q.data[TSC_CFG_LOWER_FLAG]) begin
        lower_flag_q <= 1'b0;
      end
    end
  end

  // Mode bits written by the config command
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_mode_q <= TSC_HOST_MODE_RST;
      single_q <= TSC_SINGLE_RST;
    end else if (evt_pulse && evt_q.cmd == TSC_CMD_WR_CFG) begin
      host_mode_q <= evt_q.data[TSC_CFG_HOST_MODE];
      single_q <= evt_q.data[TSC_CFG_SINGLE];
    end
  end

  // Every write of a stored cell restarts the busy timer
  assign nv_write = evt_pulse && (evt_q.cmd == TSC_CMD_WR_UPPER ||
                    evt_q.cmd == TSC_CMD_WR_LOWER || evt_q.cmd == TSC_CMD_WR_CFG);

  // Busy timer; a host ignoring the wait simply restarts it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_cnt_q <= '0;
    end else if (nv_write) begin
      nv_cnt_q <= NVW'(NV_WRITE_CYCLES);
    end else if (nv_cnt_q != '0) begin
      nv_cnt_q <= nv_cnt_q - NVW'(1);
    end
  end

  // Status image with its fixed one and zero
  always_comb begin
    cfg_img = 8'h00;
    cfg_img[TSC_CFG_DONE] = (state_q == TSC_IDLE);
    cfg_img[TSC_CFG_UPPER_FLAG] = upper_flag_q;
    cfg_img[TSC_CFG_LOWER_FLAG] = lower_flag_q;
    cfg_img[TSC_CFG_NV_BUSY] = (nv_cnt_q != '0);
    cfg_img[TSC_CFG_ONE] = 1'b1;
    cfg_img[TSC_CFG_ZERO] = 1'b0;
    cfg_img[TSC_CFG_HOST_MODE] = host_mode_q;
    cfg_img[TSC_CFG_SINGLE] = single_q;
  end

  // Image follows live state between frames, frozen inside one
  // so the link never sees a word change mid-shift
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_q <= '{temp: TSC_TEMP_RST, upper: TSC_UPPER_RST, lower: TSC_LOWER_RST,
                  count: TSC_WORD_RST, slope: TSC_WORD_RST, cfg: 8'h88};
    end else if (!frm_s2_q) begin
      snap_q <= '{temp: temp_q, upper: upper_q, lower: lower_q,
                  count: count_q, slope: slope_q, cfg: cfg_img};
    end
  end

  assign conv_start = conv_start_q;
  assign over_limit_out = over_q;
  assign under_limit_out = under_q;
  assign hysteresis_out = hyst_q;

endmodule // tsc_core
`default_nettype wire

// [tb/tsc_core_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// Port and thermostat timing seen at the core's pins
module tsc_core_checker
  import tsc_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = TSC_NV_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic frame_sel,
  input wire logic clock_convert_pin,
  input wire logic dq_oe_n,
  input wire logic sense_valid,
  input wire logic conv_start,
  input wire logic over_limit_out,
  input wire logic under_limit_out,
  input wire logic hysteresis_out
);
  logic busy_q; // A conversion is out at the sensor
  // Start to completion; a second start inside would lose a result
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q <= 1'b1;
    end else if (sense_valid) begin
      busy_q <= 1'b0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_abort_release: assert property (!frame_sel |-> dq_oe_n)
    else $error("data line driven with frame low");
  a_float_high: assert property (clock_convert_pin |-> dq_oe_n)
    else $error("data line driven while clock high");
  a_over_hold: assert property (!$past(sense_valid) |-> $stable(over_limit_out))
    else $error("over-limit moved without a result");
  a_outs_hold: assert property (!$past(sense_valid) |->
    $stable({under_limit_out, hysteresis_out}))
    else $error("thermostat output moved without a result");
  a_hyst_on_over: assert property (over_limit_out |-> hysteresis_out)
    else $error("hysteresis low at upper trip");
  a_hyst_off_under: assert property (under_limit_out && !over_limit_out |->
    !hysteresis_out)
    else $error("hysteresis high at lower trip");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_one_at_time: assert property (conv_start |-> !busy_q)
    else $error("start while converting");
  c_start: cover property (conv_start);
  c_drive: cover property (!dq_oe_n);
  c_band: cover property (hysteresis_out && !over_limit_out);
endmodule // tsc_core_checker
bind tsc_core tsc_core_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) tsc_core_checker_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .frame_sel(frame_sel),
  .clock_convert_pin(clock_convert_pin), .dq_oe_n(dq_oe_n), .sense_valid(sense_valid),
  .conv_start(conv_start), .over_limit_out(over_limit_out),
  .under_limit_out(under_limit_out), .hysteresis_out(hysteresis_out));
`default_nettype wire

// [tb/tsc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Host end of the three-wire port; it owns the link clock
module tsc_host_model #(
  parameter int NV_NS = 500
) (
  output var logic frame_sel,
  output var logic clock_convert_pin,
  output logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n
);
  localparam int HALF = 24; // Half of the 48 ns link period
  logic drv_q = 1'b0; // Host owns the data line
  logic bit_q = 1'b0; // Last bit the host sent
  realtime last_wr = -1.0e9; // End of the last storage write
  // Idle: no frame, clock parked high
  initial begin
    frame_sel = 1'b0;
    clock_convert_pin = 1'b1;
  end
  // Released line shows the inverse, never a stale copy
  assign dq_in = !dq_oe_n ? dq_out : (drv_q ? bit_q : !bit_q);
  // One frame: command byte, then n data bits, lsb first
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [8:0] wd,
      input logic wr, output logic [8:0] rd);
    logic [16:0] word;
    logic [16:0] got;
    word = {wd, cmd};
    got = '0;
    while (wr && $realtime < last_wr + NV_NS) #10;
    frame_sel = 1'b1;
    #53; // Frame select leads the first link edge by over five reference cycles
    for (int i = 0; i < 8 + n; i++) begin
      clock_convert_pin = 1'b0;
      drv_q = wr || (i < 8);
      bit_q = word[i];
      #HALF;
      got[i] = dq_oe_n ? 1'bx : dq_in;
      clock_convert_pin = 1'b1;
      #HALF;
    end
    frame_sel = 1'b0;
    drv_q = 1'b0;
    if (wr) last_wr = $realtime;
    rd = got[16:8];
    #50;
  endtask
  // Stand-alone convert pulse, frame held low
  task automatic pin_low(input int ns);
    clock_convert_pin = 1'b0;
    #(ns);
    clock_convert_pin = 1'b1;
  endtask
endmodule // tsc_host_model
`default_nettype wire

// [tb/thermostat_serial_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
// Host model on the port; sensor stand-in and model live here
module thermostat_serial_control_test;
  import tsc_pkg::*;
  localparam int NVC = 40; // Short storage write, cycles
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic frame_sel, ccp, dq_in, dq_out, dq_oe_n; // Port wires
  logic conv_start, over, under, hyst; // Core outputs
  logic s_valid = 1'b0; // Sensor completion
  logic [8:0] s_temp = 9'h000, s_cnt = 9'h000, s_slope = 9'h000, r;
  logic [8:0] m_temp = TSC_TEMP_RST, m_cnt = TSC_WORD_RST, m_slope = TSC_WORD_RST;
  int m_up = int'(TSC_UPPER_RST), m_lo = int'(TSC_LOWER_RST); // Trip points
  logic e_over = 1'b0, e_under = 1'b0, e_hyst = 1'b0, e_hf = 1'b0, e_lf = 1'b0;
  logic m_host = TSC_HOST_MODE_RST, m_single = TSC_SINGLE_RST; // Mode bits
  int err_count = 0, comparisons = 0, starts = 0, lat = 0, s0, t;
  always #5 ref_clk = ~ref_clk; // 100 MHz
  tsc_core #(.NV_WRITE_CYCLES(NVC)) tsc_core_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .frame_sel(frame_sel), .clock_convert_pin(ccp), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .sense_temp(s_temp), .sense_count(s_cnt), .sense_slope(s_slope),
    .sense_valid(s_valid), .conv_start(conv_start), .over_limit_out(over),
    .under_limit_out(under), .hysteresis_out(hyst));
  tsc_host_model #(.NV_NS(NVC * 10 + 100)) tsc_host_model_i (.frame_sel(frame_sel),
    .clock_convert_pin(ccp), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  // Count and report one comparison
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected config image
  function automatic logic [8:0] cfg(input logic nonvolatile_busy);
    return {1'b0, 1'b1, e_hf, e_lf, nonvolatile_busy, 2'b10, m_host, m_single};
  endfunction
  // Read frame, compared at once
  task automatic rd(input logic [7:0] c, input int n, input logic [8:0] exp);
    tsc_host_model_i.xfer(c, n, 9'h000, 1'b0, r);
    chk($sformatf("read %h", c), exp, r);
  endtask
  // Write frame
  task automatic wr(input logic [7:0] c, input int n, input logic [8:0] d);
    tsc_host_model_i.xfer(c, n, d, 1'b1, r);
  endtask
  // Data-less command
  task automatic send(input logic [7:0] c);
    tsc_host_model_i.xfer(c, 0, 9'h000, 1'b0, r);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Sensor: result six cycles after a start, near a trip point
  always @(posedge ref_clk) begin
    s_valid <= 1'b0;
    if (conv_start) begin
      lat <= 6;
      starts <= starts + 1;
    end else if (lat == 1) begin
      t = ($urandom_range(1) ? m_up : m_lo) + int'($urandom_range(2)) - 1;
      s_valid <= 1'b1;
      s_temp <= 9'(t);
      s_cnt <= 9'($urandom);
      s_slope <= 9'($urandom);
      lat <= 0;
    end else if (lat > 1) begin
      lat <= lat - 1;
    end
    // Model takes each result on the edge the core does
    if (s_valid) begin
      m_temp = s_temp;
      m_cnt = s_cnt;
      m_slope = s_slope;
      e_over = $signed(s_temp) >= m_up;
      e_under = $signed(s_temp) <= m_lo;
      e_hyst = e_over || (e_hyst && !e_under);
      e_hf = e_hf || e_over;
      e_lf = e_lf || e_under;
    end
  end
  // Thermostat pins against the model, every mid-cycle
  always @(negedge ref_clk) begin
    if (arst_n) begin
      chk("over", 9'(e_over), 9'(over));
      chk("under", 9'(e_under), 9'(under));
      chk("hyst", 9'(e_hyst), 9'(hyst));
    end
  end
  // Cut a hang short
  initial begin
    #300_000;
    err_count++;
    report_and_stop;
  end
  initial begin
    s0 = $urandom(15218);
    tick(10);
    arst_n <= 1'b1;
    tick(2);
    rd(TSC_CMD_RD_CFG, 8, cfg(1'b0));
    rd(TSC_CMD_RD_TEMP, 9, TSC_TEMP_RST);
    rd(TSC_CMD_RD_UPPER, 9, 9'(m_up));
    rd(TSC_CMD_RD_CNT, 9, TSC_WORD_RST);
    done("power_up");
    m_up = 40 + int'($urandom_range(20));
    m_lo = m_up - 10 - int'($urandom_range(10));
    wr(TSC_CMD_WR_UPPER, 9, 9'(m_up));
    rd(TSC_CMD_RD_CFG, 8, cfg(1'b1));
    wr(TSC_CMD_WR_LOWER, 9, 9'(m_lo));
    wr(TSC_CMD_WR_UPPER, 5, 9'h1FF);
    tick(60);
    rd(TSC_CMD_RD_UPPER, 9, 9'(m_up));
    rd(TSC_CMD_RD_LOWER, 9, 9'(m_lo));
    done("trips");
    send(TSC_CMD_START);
    tick(300);
    send(TSC_CMD_STOP);
    tick(30);
    s0 = starts;
    chk("ran", 9'h001, 9'(s0 > 10));
    tick(60);
    chk("stopped", 9'(s0), 9'(starts));
    rd(TSC_CMD_RD_CFG, 8, cfg(1'b0));
    done("continuous");
    wr(TSC_CMD_WR_CFG, 8, 9'h001);
    e_hf = 1'b0;
    e_lf = 1'b0;
    m_single = 1'b1;
    tick(60);
    rd(TSC_CMD_RD_CFG, 8, cfg(1'b0));
    s0 = starts;
    send(TSC_CMD_START);
    tick(60);
    chk("one shot", 9'(s0 + 1), 9'(starts));
    rd(TSC_CMD_RD_TEMP, 9, m_temp);
    rd(TSC_CMD_RD_CNT, 9, m_cnt);
    rd(TSC_CMD_RD_SLOPE, 9, m_slope);
    rd(TSC_CMD_RD_CNT, 9, m_slope);
    done("one_shot");
    s0 = starts;
    tsc_host_model_i.pin_low(50);
    tick(60);
    chk("pulse", 9'(s0 + 1), 9'(starts));
    s0 = starts;
    tsc_host_model_i.pin_low(800);
    tick(60);
    chk("held", 9'h001, 9'(starts - s0 > 3));
    s0 = starts;
    tick(60);
    chk("pin idle", 9'(s0), 9'(starts));
    done("stand_alone");
    wr(TSC_CMD_WR_CFG, 8, 9'h063);
    m_host = 1'b1;
    tick(60);
    rd(TSC_CMD_RD_CFG, 8, cfg(1'b0));
    s0 = starts;
    tsc_host_model_i.pin_low(50);
    tick(60);
    chk("pin ignored", 9'(s0), 9'(starts));
    send(TSC_CMD_START);
    tick(60);
    chk("serial start", 9'(s0 + 1), 9'(starts));
    rd(TSC_CMD_RD_TEMP, 9, m_temp);
    done("host_mode");
    report_and_stop;
  end
endmodule // thermostat_serial_control_test
`default_nettype wire
